// [hw/mfo_pkg.sv]
package mfo_pkg;

  // Widths
  localparam int CNT_W     = 16;
  localparam int TOT_W     = 64;
  localparam int WIDE_W    = 96;
  localparam int NARROW_W  = 64;
  localparam int ADDR_W    = 5;
  localparam int DATA_W    = 32;

  // Register byte offsets
  localparam logic [4:0] RX_TOTAL_LO_OFS = 5'h00;
  localparam logic [4:0] RX_TOTAL_HI_OFS = 5'h04;
  localparam logic [4:0] TX_TOTAL_LO_OFS = 5'h08;
  localparam logic [4:0] TX_TOTAL_HI_OFS = 5'h0C;
  localparam logic [4:0] CTRL_OFS        = 5'h10;
  localparam logic [4:0] STATUS_OFS      = 5'h14;

  // Control field positions (write-one actions, read as zero)
  localparam int CTRL_CLR_RX_BIT = 0;
  localparam int CTRL_CLR_TX_BIT = 1;

  // Status field positions
  localparam int STAT_OVF_BIT    = 0;
  localparam int STAT_UNF_BIT    = 1;
  localparam int STAT_LVL_LSB    = 8;
  localparam int STAT_LVL_W      = 8;

  // Reset values
  localparam logic [TOT_W-1:0]  TOTAL_RST = 64'h0000_0000_0000_0000;
  localparam logic [CNT_W-1:0]  COUNT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // Default stamp queue depth (packets in flight between link and client)
  localparam int STAMP_DEPTH = 4;

  // End-of-frame report from the MAC pipeline, one cycle per frame
  typedef struct packed {
    logic             done;
    logic [CNT_W-1:0] payload_len;
    logic             fcs_err;
    logic             undersize;
    logic             oversize;
    logic             len_err;
  } mfo_frame_end_type;

  // Time-of-day word as sampled at link arrival
  typedef struct packed {
    logic [WIDE_W-1:0]   wide;
    logic [NARROW_W-1:0] narrow;
  } mfo_stamp_type;

endpackage

// [hw/mfo_octet_tally.sv]
`timescale 1ns/1ps
`default_nettype none

// Per-direction payload octet reporter and cumulative total
module mfo_octet_tally (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  input  wire logic                       ce,
  input  wire mfo_pkg::mfo_frame_end_type frame_end,
  input  wire logic                       clear_total,
  output logic [mfo_pkg::CNT_W-1:0]       frame_count,
  output logic                            frame_strobe,
  output logic [mfo_pkg::TOT_W-1:0]       total
);

  logic [mfo_pkg::CNT_W-1:0] count_ff;
  logic                      strobe_ff;
  logic [mfo_pkg::TOT_W-1:0] total_ff;
  logic                      qualifying;
  logic [mfo_pkg::TOT_W-1:0] nxt_total;

  // Any error marks the frame as not qualifying
  assign qualifying = frame_end.done & ~frame_end.fcs_err
                      & ~frame_end.undersize & ~frame_end.oversize
                      & ~frame_end.len_err;

  // Add only on a strobe; an addition in the clear cycle is kept
  assign nxt_total = (clear_total ? mfo_pkg::TOTAL_RST : total_ff)
                     + (strobe_ff ? {{(mfo_pkg::TOT_W-mfo_pkg::CNT_W){1'b0}},
                                     count_ff}
                                  : mfo_pkg::TOTAL_RST);

  // Count is loaded only for qualifying frames, strobe pulses one cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff  <= mfo_pkg::COUNT_RST;
      strobe_ff <= 1'b0;
      total_ff  <= mfo_pkg::TOTAL_RST;
    end else if (ce) begin
      strobe_ff <= qualifying;
      if (qualifying) begin
        count_ff <= frame_end.payload_len;
      end
      total_ff <= nxt_total;
    end
  end

  assign frame_count  = count_ff;
  assign frame_strobe = strobe_ff;
  assign total        = total_ff;

endmodule

`default_nettype wire

// [hw/mfo_top.sv]
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Keep 64-bit cumulative receive and transmit totals of good payload octets.
// - Qualifying frame: no FCS, undersize, oversize or payload length error.
// - Each direction outputs a 16-bit per-frame payload octet count.
// - Per-direction strobe pulses when count holds a qualifying frame's octets.
// - Receive outputs on receive MAC clock, transmit outputs on transmit clock; this build runs both on sys_clk.
// - Per-frame count and strobe work with no statistics block present.
// - With time support, provide 96-bit, 64-bit or both receive stamps.
// - Every received packet gets a stamp, precision time packet or not; an arrival while the queue is full gets none.
// - Stamp buses are valid in the client start-of-packet cycle; the head stamp is registered, so it must be queued a cycle before that cycle.
// - Stamp is link arrival time, not client presentation time.
module mfo_top #(
  parameter bit EN_STAMP     = 1'b1,
  parameter bit EN_WIDE      = 1'b1,
  parameter bit EN_NARROW    = 1'b1,
  parameter int STAMP_DEPTH  = mfo_pkg::STAMP_DEPTH
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_b,
  input  wire logic                         ce,
  // Avalon-MM slave
  input  wire logic [mfo_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [mfo_pkg::DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic [mfo_pkg::DATA_W-1:0]        avs_readdata,
  output logic                              avs_waitrequest,
  // End-of-frame reports from the MAC pipeline
  input  wire mfo_pkg::mfo_frame_end_type   rx_frame_end,
  input  wire mfo_pkg::mfo_frame_end_type   tx_frame_end,
  // Per-frame octet reports
  output logic [mfo_pkg::CNT_W-1:0]         rx_frame_payload_count,
  output logic                              rx_frame_payload_count_strobe,
  output logic [mfo_pkg::CNT_W-1:0]         tx_frame_payload_count,
  output logic                              tx_frame_payload_count_strobe,
  // Time of day and packet markers
  input  wire logic [mfo_pkg::WIDE_W-1:0]   rx_tod_input_wide,
  input  wire logic [mfo_pkg::NARROW_W-1:0] rx_tod_input_narrow,
  input  wire logic                         rx_link_sop,
  input  wire logic                         rx_client_sop,
  output logic [mfo_pkg::WIDE_W-1:0]        rx_arrival_stamp_wide,
  output logic [mfo_pkg::NARROW_W-1:0]      rx_arrival_stamp_narrow
);

  localparam int PTR_W = (STAMP_DEPTH > 1) ? $clog2(STAMP_DEPTH) : 1;

  // ---------------------------------------------------------------
  // Octet tallies, one per direction. Both share sys_clk here: the
  // receive and transmit MAC clocks are one clock in this build.
  // ---------------------------------------------------------------
  logic [mfo_pkg::TOT_W-1:0] rx_total;
  logic [mfo_pkg::TOT_W-1:0] tx_total;
  logic                      clr_rx;
  logic                      clr_tx;

  // Tallies run from the frame reports alone, no statistics block needed
  mfo_octet_tally u_rx_tally (
    .sys_clk      (sys_clk),
    .rst_b        (rst_b),
    .ce           (ce),
    .frame_end    (rx_frame_end),
    .clear_total  (clr_rx),
    .frame_count  (rx_frame_payload_count),
    .frame_strobe (rx_frame_payload_count_strobe),
    .total        (rx_total)
  );

  mfo_octet_tally u_tx_tally (
    .sys_clk      (sys_clk),
    .rst_b        (rst_b),
    .ce           (ce),
    .frame_end    (tx_frame_end),
    .clear_total  (clr_tx),
    .frame_count  (tx_frame_payload_count),
    .frame_strobe (tx_frame_payload_count_strobe),
    .total        (tx_total)
  );

  // ---------------------------------------------------------------
  // Arrival stamp queue. Time is caught at link arrival and handed to
  // the client at its start of packet, so the gap between the two
  // (the receive pipeline) can hold several packets in flight.
  // ---------------------------------------------------------------
  mfo_pkg::mfo_stamp_type  stamp_mem [STAMP_DEPTH];
  mfo_pkg::mfo_stamp_type  tod_now;
  mfo_pkg::mfo_stamp_type  head_ff;
  logic [PTR_W:0]          wr_ptr_ff;
  logic [PTR_W:0]          rd_ptr_ff;
  logic [PTR_W:0]          level;
  logic                    q_empty;
  logic                    q_full;
  logic                    push;
  logic                    pop;
  logic                    ovf_ev;
  logic                    unf_ev;

  // Disabled formats capture nothing, their bus stays at zero
  assign tod_now.wide   = (EN_STAMP && EN_WIDE)
                          ? rx_tod_input_wide : '0;
  assign tod_now.narrow = (EN_STAMP && EN_NARROW)
                          ? rx_tod_input_narrow : '0;

  assign level   = wr_ptr_ff - rd_ptr_ff;
  assign q_empty = (level == '0);
  assign q_full  = (level == (PTR_W+1)'(STAMP_DEPTH));
  // Every arriving packet is stamped unless the queue is full, its type is never looked at
  assign push    = EN_STAMP && rx_link_sop && !q_full;
  assign pop     = EN_STAMP && rx_client_sop && !q_empty;
  assign ovf_ev  = EN_STAMP && rx_link_sop && q_full;
  assign unf_ev  = EN_STAMP && rx_client_sop && q_empty;

  // Store time of day at link arrival
  always_ff @(posedge sys_clk) begin
    if (ce && push) begin
      stamp_mem[wr_ptr_ff[PTR_W-1:0]] <= tod_now;
    end
  end

  // Queue pointers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

  // Head stamp is mirrored into flops every cycle, so the buses already
  // show it when the client start of packet arrives. Costs one cycle:
  // a stamp must be queued a cycle before its client start of packet.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      head_ff <= '0;
    end else if (ce) begin
      head_ff <= q_empty ? '0 : stamp_mem[rd_ptr_ff[PTR_W-1:0]];
    end
  end

  assign rx_arrival_stamp_wide   = head_ff.wide;
  assign rx_arrival_stamp_narrow = head_ff.narrow;

  // ---------------------------------------------------------------
  // Avalon-MM slave: one wait cycle on every access
  // ---------------------------------------------------------------
  logic                        ack_ff;
  logic [mfo_pkg::DATA_W-1:0]  rdata_ff;
  logic [mfo_pkg::DATA_W-1:0]  rx_hi_snap_ff;
  logic [mfo_pkg::DATA_W-1:0]  tx_hi_snap_ff;
  logic                        ovf_ff;
  logic                        unf_ff;
  logic                        req;
  logic                        wr_take;
  logic                        rd_first;
  logic [4:0]                  ofs;
  logic                        sel_rx_lo;
  logic                        sel_rx_hi;
  logic                        sel_tx_lo;
  logic                        sel_tx_hi;
  logic                        sel_ctrl;
  logic                        sel_stat;
  logic [mfo_pkg::DATA_W-1:0]  stat_word;
  logic [mfo_pkg::DATA_W-1:0]  nxt_rdata;
  logic                        clr_ovf;
  logic                        clr_unf;

  // Address decode on aligned byte offsets
  assign ofs       = {avs_address[4:2], 2'b00};
  assign sel_rx_lo = (ofs == mfo_pkg::RX_TOTAL_LO_OFS);
  assign sel_rx_hi = (ofs == mfo_pkg::RX_TOTAL_HI_OFS);
  assign sel_tx_lo = (ofs == mfo_pkg::TX_TOTAL_LO_OFS);
  assign sel_tx_hi = (ofs == mfo_pkg::TX_TOTAL_HI_OFS);
  assign sel_ctrl  = (ofs == mfo_pkg::CTRL_OFS);
  assign sel_stat  = (ofs == mfo_pkg::STATUS_OFS);

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_ff;
  assign wr_take         = avs_write & ack_ff;
  assign rd_first        = avs_read & ~ack_ff;

  // Write-one actions; only byte lane 0 carries them
  assign clr_rx  = wr_take & sel_ctrl & avs_byteenable[0]
                   & avs_writedata[mfo_pkg::CTRL_CLR_RX_BIT];
  assign clr_tx  = wr_take & sel_ctrl & avs_byteenable[0]
                   & avs_writedata[mfo_pkg::CTRL_CLR_TX_BIT];
  assign clr_ovf = wr_take & sel_stat & avs_byteenable[0]
                   & avs_writedata[mfo_pkg::STAT_OVF_BIT];
  assign clr_unf = wr_take & sel_stat & avs_byteenable[0]
                   & avs_writedata[mfo_pkg::STAT_UNF_BIT];

  // Status: sticky queue faults and current queue level
  always_comb begin
    stat_word = mfo_pkg::RDATA_RST;
    stat_word[mfo_pkg::STAT_OVF_BIT] = ovf_ff;
    stat_word[mfo_pkg::STAT_UNF_BIT] = unf_ff;
    stat_word[mfo_pkg::STAT_LVL_LSB +: mfo_pkg::STAT_LVL_W] =
      mfo_pkg::STAT_LVL_W'(level);
  end

  // Read mux; unmapped offsets and the control word read as zero.
  // The high half comes from a snapshot taken at the low-half read so
  // a 64-bit total read as low then high is never torn.
  assign nxt_rdata = sel_rx_lo ? rx_total[31:0]
                   : sel_rx_hi ? rx_hi_snap_ff
                   : sel_tx_lo ? tx_total[31:0]
                   : sel_tx_hi ? tx_hi_snap_ff
                   : sel_stat  ? stat_word
                   : mfo_pkg::RDATA_RST;

  // Handshake and read data
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_ff   <= 1'b0;
      rdata_ff <= mfo_pkg::RDATA_RST;
    end else if (ce) begin
      ack_ff <= req & ~ack_ff;
      if (rd_first) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // High-half snapshots
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_hi_snap_ff <= mfo_pkg::RDATA_RST;
      tx_hi_snap_ff <= mfo_pkg::RDATA_RST;
    end else if (ce && rd_first) begin
      if (sel_rx_lo) begin
        rx_hi_snap_ff <= rx_total[63:32];
      end
      if (sel_tx_lo) begin
        tx_hi_snap_ff <= tx_total[63:32];
      end
    end
  end

  // Sticky faults: a new event in the clear cycle wins
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ovf_ff <= 1'b0;
      unf_ff <= 1'b0;
    end else if (ce) begin
      ovf_ff <= ovf_ev | (ovf_ff & ~clr_ovf);
      unf_ff <= unf_ev | (unf_ff & ~clr_unf);
    end
  end

  assign avs_readdata = rdata_ff;

endmodule

`default_nettype wire

// [tb/mfo_tod_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Free-running time-of-day source for the receive path
module mfo_tod_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  output logic [95:0]      tod_wide_ff,
  output logic [63:0]      tod_narrow_ff
);
  // Adds one 100 ns period each cycle; seconds never roll over, runs are short
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tod_wide_ff   <= 96'h0000_0000_0001_0000_0000_0000;
      tod_narrow_ff <= 64'h0000_0001_0000_0000;
    end else begin
      tod_wide_ff   <= tod_wide_ff + 96'h0064_0000;
      tod_narrow_ff <= tod_narrow_ff + 64'h0064_0000;
    end
  end
endmodule

`default_nettype wire

// [tb/mfo_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none

module mfo_top_sva (
  input wire logic                         sys_clk,
  input wire logic                         rst_b,
  input wire logic                         ce,
  input wire logic                         avs_read,
  input wire logic                         avs_write,
  input wire logic                         avs_waitrequest,
  input wire mfo_pkg::mfo_frame_end_type   rx_frame_end,
  input wire mfo_pkg::mfo_frame_end_type   tx_frame_end,
  input wire logic [mfo_pkg::CNT_W-1:0]    rx_frame_payload_count,
  input wire logic                         rx_frame_payload_count_strobe,
  input wire logic                         tx_frame_payload_count_strobe,
  input wire logic [mfo_pkg::WIDE_W-1:0]   rx_tod_input_wide,
  input wire logic [mfo_pkg::NARROW_W-1:0] rx_tod_input_narrow,
  input wire logic                         rx_link_sop,
  input wire logic                         rx_client_sop,
  input wire logic [mfo_pkg::WIDE_W-1:0]   rx_arrival_stamp_wide,
  input wire logic [mfo_pkg::NARROW_W-1:0] rx_arrival_stamp_narrow
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Frame ends taken while running; low four bits are the error flags
  wire logic rx_take = ce & rx_frame_end.done;
  wire logic rx_good = rx_take & ~|rx_frame_end[3:0];
  wire logic tx_good = ce & tx_frame_end.done & ~|tx_frame_end[3:0];
  // Empty queue shows zero, and a push one cycle back is still in flight
  wire logic fresh = rx_link_sop & ce & (rx_arrival_stamp_narrow == '0);

  property p_rx_strobe;
    rx_good |=> rx_frame_payload_count_strobe;
  endproperty
  a_rx_strobe: assert property (p_rx_strobe) else $error("rx strobe missing");
  property p_rx_quiet;
    ce && !rx_good |=> !rx_frame_payload_count_strobe;
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("rx strobe spurious");
  property p_rx_count;
    rx_good |=> rx_frame_payload_count == $past(rx_frame_end.payload_len);
  endproperty
  a_rx_count: assert property (p_rx_count) else $error("rx count wrong");
  property p_rx_hold;
    ce && !rx_good |=> $stable(rx_frame_payload_count);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx count moved");
  property p_tx_strobe;
    tx_good |=> tx_frame_payload_count_strobe;
  endproperty
  a_tx_strobe: assert property (p_tx_strobe) else $error("tx strobe missing");
  property p_tx_quiet;
    ce && !tx_good |=> !tx_frame_payload_count_strobe;
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("tx strobe spurious");
  property p_stamp_n;
    !$past(rx_link_sop) && fresh ##1 ce
      |=> rx_arrival_stamp_narrow == $past(rx_tod_input_narrow, 2);
  endproperty
  a_stamp_n: assert property (p_stamp_n) else $error("narrow stamp wrong");
  property p_stamp_w;
    !$past(rx_link_sop) && fresh ##1 ce
      |=> rx_arrival_stamp_wide == $past(rx_tod_input_wide, 2);
  endproperty
  a_stamp_w: assert property (p_stamp_w) else $error("wide stamp wrong");
  // One wait state on every bus request
  property p_wait;
    $rose(avs_read | avs_write) && ce |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus wait state wrong");

  c_good: cover property (rx_good);
  c_bad: cover property (rx_take && !rx_good);
  c_pop: cover property (rx_client_sop && rx_arrival_stamp_narrow != '0);
endmodule

bind mfo_top mfo_top_sva u_sva (
  .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .rx_frame_end(rx_frame_end), .tx_frame_end(tx_frame_end),
  .rx_frame_payload_count(rx_frame_payload_count),
  .rx_frame_payload_count_strobe(rx_frame_payload_count_strobe),
  .tx_frame_payload_count_strobe(tx_frame_payload_count_strobe),
  .rx_tod_input_wide(rx_tod_input_wide),
  .rx_tod_input_narrow(rx_tod_input_narrow),
  .rx_link_sop(rx_link_sop), .rx_client_sop(rx_client_sop),
  .rx_arrival_stamp_wide(rx_arrival_stamp_wide),
  .rx_arrival_stamp_narrow(rx_arrival_stamp_narrow)
);

`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic                       sys_clk, rst_b, ce, rd, wr, wreq;
  logic [4:0]                 addr;
  logic [31:0]                wdata, rdata, q;
  logic [3:0]                 ben;
  mfo_pkg::mfo_frame_end_type rx_fe, tx_fe;
  logic [15:0]                rx_cnt, tx_cnt;
  logic                       rx_stb, tx_stb, link_sop, client_sop;
  logic [95:0]                tod_w, st_w;
  logic [63:0]                tod_n, st_n;
  int                         bad_count, check_count;

  mfo_top u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(ben), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .rx_frame_end(rx_fe), .tx_frame_end(tx_fe),
    .rx_frame_payload_count(rx_cnt), .rx_frame_payload_count_strobe(rx_stb),
    .tx_frame_payload_count(tx_cnt), .tx_frame_payload_count_strobe(tx_stb),
    .rx_tod_input_wide(tod_w), .rx_tod_input_narrow(tod_n),
    .rx_link_sop(link_sop), .rx_client_sop(client_sop),
    .rx_arrival_stamp_wide(st_w), .rx_arrival_stamp_narrow(st_n));
  mfo_tod_model u_tod (.sys_clk(sys_clk), .rst_b(rst_b),
    .tod_wide_ff(tod_w), .tod_narrow_ff(tod_n));

  // 100 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [95:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Bus cycle held until the edge that sees waitrequest low
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    rd    <= !w;
    wr    <= w;
    n = 0;
    // Waitrequest is judged at the rising edge itself, where the slave takes it
    do begin
      @(posedge sys_clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (wreq !== 1'b0) begin
      bad_count++;
      finish_test();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Low word first so the high word is the matching snapshot
  task automatic total(input logic [4:0] lo, input logic [63:0] exp);
    logic [31:0] l;
    av(1'b0, lo, 32'h0);
    l = q;
    av(1'b0, lo + 5'h04, 32'h0);
    chk("total", {q, l}, exp);
  endtask

  task automatic frame(input logic t, input logic [15:0] len,
                       input logic [3:0] err, input logic [15:0] cnt);
    @(posedge sys_clk);
    if (t) tx_fe <= {1'b1, len, err};
    else rx_fe <= {1'b1, len, err};
    @(posedge sys_clk);
    rx_fe <= '0;
    tx_fe <= '0;
    @(negedge sys_clk);
    chk("strobe", t ? tx_stb : rx_stb, err == 4'h0);
    chk("count", t ? tx_cnt : rx_cnt, cnt);
    @(negedge sys_clk);
    chk("strobe_end", t ? tx_stb : rx_stb, 1'b0);
  endtask

  // Good frames, then every error kind on both directions, then totals
  task automatic t_frames;
    frame(1'b0, 16'h0040, 4'h0, 16'h0040);
    frame(1'b0, 16'h05DC, 4'h0, 16'h05DC);
    frame(1'b1, 16'h0100, 4'h0, 16'h0100);
    for (int i = 0; i < 4; i++) begin
      frame(1'b0, 16'h0033, 4'h1 << i, 16'h05DC);
      frame(1'b1, 16'h0033, 4'h1 << i, 16'h0100);
    end
    total(mfo_pkg::RX_TOTAL_LO_OFS, 64'h061C);
    total(mfo_pkg::TX_TOTAL_LO_OFS, 64'h0100);
    av(1'b1, mfo_pkg::CTRL_OFS, 32'h1);
    total(mfo_pkg::RX_TOTAL_LO_OFS, 64'h0);
    total(mfo_pkg::TX_TOTAL_LO_OFS, 64'h0100);
    av(1'b0, mfo_pkg::CTRL_OFS, 32'h0);
    chk("ctrl_read", q, 32'h0);
    av(1'b0, 5'h18, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask

  // Frame end while the clock enable is low is not taken
  task automatic t_freeze;
    @(posedge sys_clk);
    ce <= 1'b0;
    rx_fe <= {1'b1, 16'h0010, 4'h0};
    @(posedge sys_clk);
    rx_fe <= '0;
    repeat (2) @(posedge sys_clk);
    ce <= 1'b1;
    @(negedge sys_clk);
    chk("freeze_strobe", rx_stb, 1'b0);
    chk("freeze_count", rx_cnt, 16'h05DC);
    total(mfo_pkg::RX_TOTAL_LO_OFS, 64'h0);
  endtask

  // Client start with no stamp queued, then one arrival too many
  task automatic t_status;
    @(posedge sys_clk);
    client_sop <= 1'b1;
    @(posedge sys_clk);
    client_sop <= 1'b0;
    av(1'b0, mfo_pkg::STATUS_OFS, 32'h0);
    chk("status_unf", q, 32'h0000_0002);
    av(1'b1, mfo_pkg::STATUS_OFS, 32'h0000_0003);
    av(1'b0, mfo_pkg::STATUS_OFS, 32'h0);
    chk("status_clr", q, 32'h0000_0000);
    @(posedge sys_clk);
    link_sop <= 1'b1;
    repeat (5) @(posedge sys_clk);
    link_sop <= 1'b0;
    av(1'b0, mfo_pkg::STATUS_OFS, 32'h0);
    chk("status_ovf", q, 32'h0000_0401);
  endtask

  // Three arrivals, consumed later; each stamp is the arrival time
  task automatic t_stamps;
    logic [95:0] ew[3];
    logic [63:0] en[3];
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      link_sop <= 1'b1;
      @(negedge sys_clk);
      ew[i] = tod_w;
      en[i] = tod_n;
      @(posedge sys_clk);
      link_sop <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      client_sop <= 1'b1;
      @(negedge sys_clk);
      chk("stamp_narrow", st_n, en[i]);
      chk("stamp_wide", st_w, ew[i]);
      @(posedge sys_clk);
      client_sop <= 1'b0;
    end
    repeat (2) @(negedge sys_clk);
    chk("stamp_empty", st_n, 64'h0);
  endtask

  // Watchdog ends a hung run
  initial begin
    #2000000;
    bad_count++;
    finish_test();
  end

  // Main sequence
  initial begin
    ce = 1'b1;
    rst_b = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 5'h00;
    wdata = 32'h0;
    ben = 4'hF;
    rx_fe = '0;
    tx_fe = '0;
    link_sop = 1'b0;
    client_sop = 1'b0;
    bad_count = 0;
    check_count = 0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_frames();
    t_freeze();
    t_stamps();
    t_status();
    finish_test();
  end
endmodule

`default_nettype wire
